// >>> logic/pmh_cfg.svh
// Constants for the page, move and hold-flag instruction unit
`ifndef PMH_CFG_SVH
`define PMH_CFG_SVH

// ---------------------------------------------------------------
// Instruction word layout
// ---------------------------------------------------------------
`define PMH_INSTR_W        16
`define PMH_ADDR_W         7
`define PMH_NIB_W          4
`define PMH_STORE_OP       5'b11011
`define PMH_PAGE_OP        8'b01011101
`define PMH_CARRY_OP       9'b010110010
`define PMH_UPPER_OP       9'b010010011
`define PMH_LOWER_OP       9'b010010010
`define PMH_PAGE_BITS      3
`define PMH_WR_PAGE        3'h0

// ---------------------------------------------------------------
// Hold-release flag positions
// ---------------------------------------------------------------
`define PMH_FLAG_W         8
`define PMH_FLAG_RSVD      3
`define PMH_FLAG_RSVD_MASK 8'hf7

// ---------------------------------------------------------------
// Register map, byte addresses
// ---------------------------------------------------------------
`define PMH_WB_ADR_W       10
`define PMH_REG_STATUS     10'h000
`define PMH_REG_MASK       10'h004
`define PMH_REG_CORE       10'h008
`define PMH_RAM_WIN_BIT    9

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PMH_RST_NIB        4'h0
`define PMH_RST_FLAGS      8'h00
`define PMH_RST_WORD       32'h0000_0000

`endif

// >>> logic/pmh_pkg.sv
// Types shared by the page, move and hold-flag instruction unit
package pmh_pkg;

    // ---------------------------------------------------------------
    // Execution states, one-hot
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PMH_IDLE   = 2'b01,  // Ready for a new instruction
        PMH_STORE2 = 2'b10   // Second cycle of the indirect store
    } pmh_state_e;

    // ---------------------------------------------------------------
    // Decoded instruction kinds
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        PMH_OP_NONE  = 3'h0,
        PMH_OP_STORE = 3'h1,
        PMH_OP_PAGE  = 3'h2,
        PMH_OP_CARRY = 3'h3,
        PMH_OP_UPPER = 3'h4,
        PMH_OP_LOWER = 3'h5
    } pmh_op_e;

    // ---------------------------------------------------------------
    // Whole state of the execution unit
    // ---------------------------------------------------------------
    typedef struct packed {
        pmh_state_e  state;       // Sequencer
        logic [6:0]  ptr_cell;    // Address of the pointer cell
        logic [3:0]  ptr;         // Pointer latched in cycle one
        logic [3:0]  store_data;  // Working register latched in cycle one
        logic [3:0]  page_reg;    // Page register
        logic [3:0]  accumulator; // Accumulator
        logic        zero_flag;   // Zero flag
        logic [7:0]  hold_flags;  // Hold-release cause flags
        logic [7:0]  irq_status;  // Sticky interrupt status
        logic [7:0]  irq_mask;    // Interrupt mask
        logic        irq;         // Interrupt line
        logic        busy;        // Two-cycle store in progress
        logic        done;        // Instruction completed
        logic        wb_ack;      // Bus acknowledge
        logic [31:0] wb_dat;      // Bus read data
    } pmh_state_s;

endpackage : pmh_pkg

// >>> logic/pmh_mem_if.sv
// Carrier between the execution unit and its data memory
`timescale 1ns/10ps
interface pmh_mem_if;
    logic [6:0] ra_addr;  // Read port a address
    logic [3:0] ra_data;  // Read port a data
    logic [6:0] rb_addr;  // Read port b address
    logic [3:0] rb_data;  // Read port b data
    logic [6:0] rbus_addr;  // Read port c address
    logic [3:0] rbus_data;  // Read port c data
    logic       we;       // Write enable
    logic [6:0] waddr;    // Write address
    logic [3:0] wdata;    // Write data

    modport user (output ra_addr, rb_addr, rbus_addr, we, waddr, wdata,
                  input  ra_data, rb_data, rbus_data);
    modport mem  (input  ra_addr, rb_addr, rbus_addr, we, waddr, wdata,
                  output ra_data, rb_data, rbus_data);
endinterface : pmh_mem_if

// >>> logic/pmh_data_ram.sv
// Data memory of 128 nibbles with three read ports and one write port
`timescale 1ns/10ps
module pmh_data_ram
    import pmh_pkg::*;
(
    input  wire logic clk_i,
    pmh_mem_if.mem    bus
);
    // ---------------------------------------------------------------
    // Storage, no reset: contents are undefined until written
    // ---------------------------------------------------------------
    logic [3:0] cells [0:127];

    // Reads are combinational so one-cycle instructions fit
    assign bus.ra_data = cells[bus.ra_addr];
    assign bus.rb_data = cells[bus.rb_addr];
    assign bus.rbus_data = cells[bus.rbus_addr];

    // Single write port
    always_ff @(posedge clk_i) begin
        if (bus.we) begin
            cells[bus.waddr] <= bus.wdata;
        end
    end
endmodule : pmh_data_ram

// >>> logic/pmh_exec.sv
// Execution unit for page, indirect store, carry and hold-flag moves
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "pmh_cfg.svh"
module pmh_exec
    import pmh_pkg::*;
(
    input  wire logic        clk_i,          // Core clock
    input  wire logic        rst_i,          // Synchronous reset
    input  wire logic [15:0] instr_i,        // Instruction word
    input  wire logic        instr_valid_i,  // Instruction present
    input  wire logic        carry_flag_i,   // Carry flag of the core
    input  wire logic [7:0]  wake_i,         // Hold-release event pulses
    input  wire logic [31:0] wb_adr_i,       // Bus address
    input  wire logic [31:0] wb_dat_i,       // Bus write data
    input  wire logic [3:0]  wb_sel_i,       // Bus byte enables
    input  wire logic        wb_we_i,        // Bus write
    input  wire logic        wb_cyc_i,       // Bus cycle
    input  wire logic        wb_stb_i,       // Bus strobe
    output logic [31:0]      wb_dat_o,       // Bus read data
    output logic             wb_ack_o,       // Bus acknowledge
    output logic [3:0]       accumulator_o,  // Accumulator
    output logic             zero_flag_o,    // Zero flag
    output logic [3:0]       page_reg_o,     // Page register
    output logic             busy_o,         // Store in second cycle
    output logic             done_o,         // Instruction finished
    output logic             irq_o           // Interrupt request
);
    // ---------------------------------------------------------------
    // Decoding helper
    // ---------------------------------------------------------------
    function automatic pmh_op_e decode(input logic [15:0] w);
        if (w[15:11] == `PMH_STORE_OP) begin
            decode = PMH_OP_STORE;
        end else if (w[15:8] == `PMH_PAGE_OP) begin
            decode = PMH_OP_PAGE;
        end else if (w[15:7] == `PMH_CARRY_OP) begin
            decode = PMH_OP_CARRY;
        end else if (w[15:7] == `PMH_UPPER_OP) begin
            decode = PMH_OP_UPPER;
        end else if (w[15:7] == `PMH_LOWER_OP) begin
            decode = PMH_OP_LOWER;
        end else begin
            decode = PMH_OP_NONE;
        end
    endfunction : decode

    // Nibble to zero flag
    function automatic logic is_zero(input logic [3:0] v);
        is_zero = (v == `PMH_RST_NIB);
    endfunction : is_zero

    // ---------------------------------------------------------------
    // State and memory
    // ---------------------------------------------------------------
    pmh_state_s  st;         // Registered state
    pmh_state_s  next_st;    // Next state
    pmh_op_e     op;         // Decoded instruction
    logic        take;       // Instruction accepted this edge
    logic [6:0]  cell_addr;  // Address field of the word
    logic [6:0]  wr_addr;    // Working register cell
    logic        wb_req;     // New bus request
    logic [9:0]  wb_off;     // Bus offset
    logic        wb_ram;     // Access falls in the memory window
    logic        exec_we;    // Execution writes memory
    logic [6:0]  exec_wa;    // Execution write address
    logic [3:0]  exec_wd;    // Execution write data
    logic [3:0]  result;     // Value for the moving reads
    logic [7:0]  flag_clr;   // Flags cleared by a read
    logic [7:0]  stat_clr;   // Status cleared by a bus read

    pmh_mem_if mem ();

    pmh_data_ram u_ram (
        .clk_i (clk_i),
        .bus   (mem.mem)
    );

    assign op        = decode(instr_i);
    assign take      = instr_valid_i && (st.state == PMH_IDLE) && (op != PMH_OP_NONE);
    assign cell_addr = instr_i[6:0];
    assign wr_addr   = {`PMH_WR_PAGE, instr_i[10:7]};
    assign wb_off    = wb_adr_i[9:0];
    assign wb_req    = wb_cyc_i && wb_stb_i && !st.wb_ack;
    assign wb_ram    = wb_off[`PMH_RAM_WIN_BIT];

    // Port a reads the addressed cell, b the working register, c serves the bus
    assign mem.ra_addr = cell_addr;
    assign mem.rb_addr = wr_addr;
    assign mem.rbus_addr = wb_off[8:2];

    // ---------------------------------------------------------------
    // Memory write selection; execution wins, the bus waits a cycle
    // ---------------------------------------------------------------
    always_comb begin
        exec_we = 1'b0;
        exec_wa = cell_addr;
        exec_wd = `PMH_RST_NIB;
        result  = `PMH_RST_NIB;
        if (st.state == PMH_STORE2) begin
            exec_we = 1'b1;
            exec_wa = {st.page_reg[`PMH_PAGE_BITS-1:0], st.ptr};
            exec_wd = st.store_data;
        end else if (take) begin
            case (op)
                PMH_OP_CARRY: begin
                    result  = {3'h0, carry_flag_i};
                    exec_we = 1'b1;
                end
                PMH_OP_UPPER: begin
                    result  = st.hold_flags[7:4];
                    exec_we = 1'b1;
                end
                PMH_OP_LOWER: begin
                    result  = {1'b0, st.hold_flags[2:0]};
                    exec_we = 1'b1;
                end
                default: begin
                    exec_we = 1'b0;
                end
            endcase
            exec_wd = result;
        end
    end

    assign mem.we    = exec_we || (wb_req && wb_we_i && wb_ram && wb_sel_i[0]);
    assign mem.waddr = exec_we ? exec_wa : wb_off[8:2];
    assign mem.wdata = exec_we ? exec_wd : wb_dat_i[3:0];

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        next_st.busy = 1'b0;
        flag_clr     = `PMH_RST_FLAGS;
        stat_clr     = `PMH_RST_FLAGS;

        // Sequencer
        case (st.state)
            PMH_IDLE: begin
                if (take) begin
                    case (op)
                        PMH_OP_STORE: begin
                            // Latch pointer and data, write next cycle
                            next_st.ptr        = mem.ra_data;
                            next_st.store_data = mem.rb_data;
                            next_st.ptr_cell   = cell_addr;
                            next_st.state      = PMH_STORE2;
                            next_st.busy       = 1'b1;
                        end
                        PMH_OP_PAGE: begin
                            next_st.page_reg = mem.ra_data;
                            next_st.done     = 1'b1;
                        end
                        PMH_OP_CARRY: begin
                            next_st.accumulator = result;
                            next_st.zero_flag   = is_zero(result);
                            next_st.done        = 1'b1;
                        end
                        PMH_OP_UPPER: begin
                            next_st.accumulator = result;
                            next_st.zero_flag   = is_zero(result);
                            next_st.done        = 1'b1;
                            flag_clr            = 8'hf0;
                        end
                        PMH_OP_LOWER: begin
                            next_st.accumulator = result;
                            next_st.zero_flag   = is_zero(result);
                            next_st.done        = 1'b1;
                            flag_clr            = 8'h0f;
                        end
                        default: begin
                            next_st.state = PMH_IDLE;
                        end
                    endcase
                end
            end
            PMH_STORE2: begin
                // Write happens this cycle through the memory port
                next_st.state = PMH_IDLE;
                next_st.done  = 1'b1;
            end
            default: begin
                next_st.state = PMH_IDLE;
            end
        endcase

        // Bus slave: answer one cycle after the request, unless a memory-window write meets an execution write
        next_st.wb_ack = 1'b0;
        if (wb_req && !(wb_ram && wb_we_i && exec_we)) begin
            next_st.wb_ack = 1'b1;
            next_st.wb_dat = `PMH_RST_WORD;
            if (wb_ram) begin
                next_st.wb_dat = {28'h0, mem.rbus_data};
            end else begin
                case (wb_off)
                    `PMH_REG_STATUS: begin
                        next_st.wb_dat = {24'h0, st.irq_status};
                        if (!wb_we_i) begin
                            stat_clr = 8'hff;   // Read clears
                        end
                    end
                    `PMH_REG_MASK: begin
                        next_st.wb_dat = {24'h0, st.irq_mask};
                        if (wb_we_i && wb_sel_i[0]) begin
                            next_st.irq_mask = wb_dat_i[7:0];
                        end
                    end
                    `PMH_REG_CORE: begin
                        next_st.wb_dat = {12'h0, st.hold_flags, 3'h0, st.zero_flag,
                                          st.accumulator, st.page_reg};
                    end
                    default: begin
                        next_st.wb_dat = `PMH_RST_WORD;   // Unmapped reads zero
                    end
                endcase
            end
        end

        // Sticky flags: a set in the clearing cycle wins
        next_st.hold_flags = ((st.hold_flags & ~flag_clr) | wake_i) & `PMH_FLAG_RSVD_MASK;
        next_st.irq_status = ((st.irq_status & ~stat_clr) | wake_i) & `PMH_FLAG_RSVD_MASK;
        next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '{state: PMH_IDLE, ptr_cell: 7'h00, ptr: `PMH_RST_NIB, store_data: `PMH_RST_NIB,
                    page_reg: `PMH_RST_NIB, accumulator: `PMH_RST_NIB, zero_flag: 1'b1,
                    hold_flags: `PMH_RST_FLAGS, irq_status: `PMH_RST_FLAGS, irq_mask: `PMH_RST_FLAGS,
                    irq: 1'b0, busy: 1'b0, done: 1'b0, wb_ack: 1'b0, wb_dat: `PMH_RST_WORD};
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o      = st.wb_dat;
    assign wb_ack_o      = st.wb_ack;
    assign accumulator_o = st.accumulator;
    assign zero_flag_o   = st.zero_flag;
    assign page_reg_o    = st.page_reg;
    assign busy_o        = st.busy;
    assign done_o        = st.done;
    assign irq_o         = st.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    store_two_cycle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && op == PMH_OP_STORE |=> busy_o && !done_o ##1 done_o && !busy_o)
        else $error("Indirect store did not take two cycles");

    store_target_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st.state == PMH_STORE2 |-> mem.we && mem.waddr == {page_reg_o[2:0], st.ptr}
                                   && mem.wdata == st.store_data)
        else $error("Indirect store target wrong");

    page_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && op == PMH_OP_PAGE |=> page_reg_o == $past(mem.ra_data) && done_o)
        else $error("Page load failed");

    carry_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && op == PMH_OP_CARRY |-> mem.we && mem.wdata == {3'h0, carry_flag_i}
                                       ##1 accumulator_o == {3'h0, $past(carry_flag_i)})
        else $error("Carry read result wrong");

    zero_update_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && (op == PMH_OP_CARRY || op == PMH_OP_UPPER || op == PMH_OP_LOWER)
        |=> zero_flag_o == (accumulator_o == 4'h0))
        else $error("Zero flag not updated");

    upper_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && op == PMH_OP_UPPER |=> accumulator_o == $past(st.hold_flags[7:4]))
        else $error("Upper hold read wrong");

    lower_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        take && op == PMH_OP_LOWER |=> accumulator_o == {1'b0, $past(st.hold_flags[2:0])})
        else $error("Lower hold read wrong");

    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wake_i[6] |=> st.hold_flags[6] && !st.hold_flags[3])
        else $error("Hold flag not set by its event");

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge held too long");

endmodule : pmh_exec

// >>> bench/tb_page_move_hold_flag_instr.sv
// Self-checking bench for the page, move and hold-flag execution unit
`timescale 1ns/10ps
`include "pmh_cfg.svh"
module tb_page_move_hold_flag_instr
    import pmh_pkg::*;
;
    // ---------------------------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------------------------
    logic        clk_i = 1'b0;     // Core clock
    logic        rst_i = 1'b1;     // Synchronous reset
    logic [15:0] instr_i = 16'h0;  // Instruction word
    logic        instr_valid_i = 1'b0;
    logic        carry_flag_i = 1'b0;
    logic [7:0]  wake_i = 8'h0;    // Wake event pulses
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [3:0]  accumulator_o;
    logic        zero_flag_o;
    logic [3:0]  page_reg_o;
    logic        busy_o;
    logic        done_o;
    logic        irq_o;
    int          err_total = 0;    // Mismatches
    int          num_checks = 0;   // Comparisons
    logic [31:0] rd_q[$];          // Expected bus read data
    logic [31:0] done_q[$];        // Expected {acc, zero, page} at done
    logic [3:0]  e_acc = 4'h0;     // Model accumulator
    logic        e_zero = 1'b1;    // Model zero flag
    logic [3:0]  e_page = 4'h0;    // Model page register

    always #5 clk_i = ~clk_i;

    pmh_exec dut (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
        .carry_flag_i(carry_flag_i), .wake_i(wake_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .accumulator_o(accumulator_o),
        .zero_flag_o(zero_flag_o), .page_reg_o(page_reg_o), .busy_o(busy_o), .done_o(done_o),
        .irq_o(irq_o));

    // ---------------------------------------------------------------
    // Reporting helpers
    // ---------------------------------------------------------------
    task final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] ram(input logic [6:0] i);
        return 32'h200 + 32'(i) * 4;  // Cell window of the bus map
    endfunction : ram

    // ---------------------------------------------------------------
    // Monitor: each result seen takes the oldest note off its queue
    // ---------------------------------------------------------------
    always @(posedge clk_i) begin
        if (!rst_i && wb_ack_o === 1'b1 && !wb_we_i) begin
            if (rd_q.size() == 0) chk(32'h1, 32'h0, "unexpected read ack");
            else chk(wb_dat_o, rd_q.pop_front(), "bus read");
        end
        if (!rst_i && done_o === 1'b1) begin
            if (done_q.size() == 0) chk(32'h1, 32'h0, "unexpected done");
            else chk({23'h0, accumulator_o, zero_flag_o, page_reg_o}, done_q.pop_front(), "core state");
        end
    end

    // ---------------------------------------------------------------
    // Bus and instruction drivers, bounded waits only
    // ---------------------------------------------------------------
    task wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(32'h1, 32'h0, "bus timeout");
            final_report();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);  // Idle cycle between requests
    endtask : wb

    task rd(input logic [31:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask : rd

    // Issues one word; stores must report busy then finish one cycle later
    task run(input logic [15:0] w);
        int n;
        done_q.push_back({23'h0, e_acc, e_zero, e_page});
        instr_i       <= w;
        instr_valid_i <= 1'b1;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n == 1 && w[15:11] == `PMH_STORE_OP) chk({31'h0, busy_o}, 32'h1, "store busy");
        end while (done_o !== 1'b1 && n < 20);
        chk(n, (w[15:11] == `PMH_STORE_OP) ? 2 : 1, "cycle count");
        if (n >= 20) final_report();
    endtask : run

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        logic [3:0] pv, wv, ptr;
        logic [6:0] r;
        logic [7:0] e;
        logic       c;
        void'($urandom(76298));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`PMH_REG_CORE, 32'h100);
        rd(`PMH_REG_STATUS, 32'h0);
        rd(32'h100, 32'h0);  // Unmapped place reads zero
        $display("test reset done");
        // Page load then indirect store into the page-selected row
        for (int k = 0; k < 4; k++) begin
            pv  = 4'($urandom);
            wv  = 4'($urandom);
            ptr = 4'($urandom);
            r   = 7'(16 + $urandom % 100);
            wb(1'b1, ram(7'h7f), {28'h0, pv});
            e_page = pv;
            run({`PMH_PAGE_OP, 1'b0, 7'h7f});
            wb(1'b1, ram(7'(k)), {28'h0, wv});
            wb(1'b1, ram(r), {28'h0, ptr});
            run({`PMH_STORE_OP, 4'(k), r});
            rd(ram({pv[2:0], ptr}), {28'h0, wv});
        end
        $display("test page and store done");
        // Carry read into bit 0, upper bits cleared
        for (int k = 0; k < 6; k++) begin
            r = 7'($urandom);
            c = 1'($urandom);
            carry_flag_i <= c;
            e_acc  = {3'h0, c};
            e_zero = !c;
            run({`PMH_CARRY_OP, r});
            rd(ram(r), {28'h0, e_acc});
        end
        $display("test carry done");
        // Each wake cause in turn, seen by both reads, status and irq
        wb(1'b1, `PMH_REG_MASK, 32'hff);
        for (int i = 0; i < 8; i++) begin
            e = 8'(1 << i) & 8'hf7;
            wake_i <= 8'(1 << i);
            @(posedge clk_i);
            wake_i <= 8'h0;
            repeat (3) @(posedge clk_i);
            chk({31'h0, irq_o}, {31'h0, e != 8'h0}, "irq raised");
            e_acc  = e[7:4];
            e_zero = (e[7:4] == 4'h0);
            run({`PMH_UPPER_OP, 7'h05});
            rd(ram(7'h05), {28'h0, e[7:4]});
            e_acc  = e[3:0];
            e_zero = (e[3:0] == 4'h0);
            run({`PMH_LOWER_OP, 7'h06});
            rd(ram(7'h06), {28'h0, e[3:0]});
            rd(`PMH_REG_STATUS, {24'h0, e});
            @(posedge clk_i);
            chk({31'h0, irq_o}, 32'h0, "irq cleared");
        end
        wb(1'b1, `PMH_REG_MASK, 32'h0);
        wake_i <= 8'h01;
        @(posedge clk_i);
        wake_i <= 8'h0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0, "masked irq");
        rd(`PMH_REG_STATUS, 32'h1);
        $display("test wake flags done");
        final_report();
    end
endmodule : tb_page_move_hold_flag_instr
